// File: core/jie_consts.vh
// Constants for the JTAG programming-entry and I/O control block
`ifndef JIE_CONSTS_VH
`define JIE_CONSTS_VH
// Instruction register
`define JIE_IR_LEN 4
`define JIE_IR_CAPTURE 4'h1
`define JIE_INS_EXTEST 4'h0
`define JIE_INS_SAMPLE 4'h1
`define JIE_INS_IDCODE 4'h2
`define JIE_INS_ISC_ENABLE 4'h4
`define JIE_INS_ISC_PROGRAM 4'h5
`define JIE_INS_ISC_DISABLE 4'h6
`define JIE_INS_BYPASS 4'hf
// Data register lengths
`define JIE_PADS 8
`define JIE_BSR_LEN 6'h18
`define JIE_IDCODE_LEN 6'h20
`define JIE_PROG_LEN 6'h08
`define JIE_DR_MAX 32
// Boundary cell field positions: inputs low, outputs middle, enables high
`define JIE_BSR_IN_LSB 0
`define JIE_BSR_OUT_LSB 8
`define JIE_BSR_OE_LSB 16
// Reset values
`define JIE_IO_EN_RESET 1'b0
`endif

// File: core/jie_sync.v
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module jie_sync #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Asynchronous in, synchronous out
  input wire [WIDTH-1:0] d,
  output reg [WIDTH-1:0] q
);

  reg [WIDTH-1:0] meta;

  // First stage feeds only the second stage
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= {WIDTH{1'b0}};
      q <= {WIDTH{1'b0}};
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule // jie_sync

// File: core/jie_tap.v
// JTAG test access port with programming entry and global I/O enable
`timescale 1ns/1ps
`include "jie_consts.vh"

// How it works
// - An enable-programming instruction taken while frozen is refused and programming mode is not entered.
// - While the array is unprogrammed or being programmed the global I/O enable stays low, disabling all user I/O.
// - Sample/preload captures all pads in parallel, then shifts them out on TDO while preload data shifts in.
// - Output and enable cells capture whatever the fabric presents, undefined when unprogrammed; input cells capture the pads.
// - The standard TAP state machine and an enable/program/disable instruction flow carry the programming.
module jie_tap #(
  parameter [31:0] IDCODE_VALUE = 32'h0000_1001 // Arbitrary value
) (
  // Clock and reset
  input wire clk,
  input wire rst,
  // JTAG pins, asynchronous to clk
  input wire tck,
  input wire tms,
  input wire tdi,
  input wire trst_n,
  output reg tdo,
  output reg tdo_oe,
  // Pads and fabric view for boundary scan
  input wire [`JIE_PADS-1:0] pad_in,
  input wire [`JIE_PADS-1:0] core_out,
  input wire [`JIE_PADS-1:0] core_oe,
  // Device state from the rest of the chip, same clock
  input wire freeze_mode,
  input wire array_valid,
  input wire prog_ok,
  // Programming and I/O control outputs
  output reg io_en,
  output reg isc_mode,
  output reg isc_refused,
  output reg prog_we,
  output reg [`JIE_PROG_LEN-1:0] prog_data
);

  // One-hot TAP states
  localparam [15:0] S_TLR = 16'h0001;
  localparam [15:0] S_RTI = 16'h0002;
  localparam [15:0] S_SDS = 16'h0004;
  localparam [15:0] S_CDR = 16'h0008;
  localparam [15:0] S_SHDR = 16'h0010;
  localparam [15:0] S_E1DR = 16'h0020;
  localparam [15:0] S_PDR = 16'h0040;
  localparam [15:0] S_E2DR = 16'h0080;
  localparam [15:0] S_UDR = 16'h0100;
  localparam [15:0] S_SIS = 16'h0200;
  localparam [15:0] S_CIR = 16'h0400;
  localparam [15:0] S_SHIR = 16'h0800;
  localparam [15:0] S_E1IR = 16'h1000;
  localparam [15:0] S_PIR = 16'h2000;
  localparam [15:0] S_E2IR = 16'h4000;
  localparam [15:0] S_UIR = 16'h8000;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and TCK edge detection

  wire [3+`JIE_PADS:0] sync_q;
  reg tck_d;
  reg started;
  wire tck_s = sync_q[0];
  wire tms_s = sync_q[1];
  wire tdi_s = sync_q[2];
  wire trst_s = ~sync_q[3];
  wire [`JIE_PADS-1:0] pad_s = sync_q[3+`JIE_PADS:4];
  wire tck_rise = tck_s & ~tck_d & started;
  wire tck_fall = ~tck_s & tck_d & started;

  jie_sync #(.WIDTH(4 + `JIE_PADS)) u_sync (
    .clk(clk),
    .rst(rst),
    .d({pad_in, trst_n, tdi, tms, tck}),
    .q(sync_q)
  );

  // Delayed TCK copy; edges ignored only in the first clock after reset, before the second synchroniser stage has filled
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tck_d <= 1'b0;
      started <= 1'b0;
    end else begin
      tck_d <= tck_s;
      started <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions

  // Standard TAP next-state map
  function [15:0] tap_next;
    input [15:0] st;
    input m;
    begin
      case (st)
        S_TLR: tap_next = m ? S_TLR : S_RTI;
        S_RTI: tap_next = m ? S_SDS : S_RTI;
        S_SDS: tap_next = m ? S_SIS : S_CDR;
        S_CDR: tap_next = m ? S_E1DR : S_SHDR;
        S_SHDR: tap_next = m ? S_E1DR : S_SHDR;
        S_E1DR: tap_next = m ? S_UDR : S_PDR;
        S_PDR: tap_next = m ? S_E2DR : S_PDR;
        S_E2DR: tap_next = m ? S_UDR : S_SHDR;
        S_UDR: tap_next = m ? S_SDS : S_RTI;
        S_SIS: tap_next = m ? S_TLR : S_CIR;
        S_CIR: tap_next = m ? S_E1IR : S_SHIR;
        S_SHIR: tap_next = m ? S_E1IR : S_SHIR;
        S_E1IR: tap_next = m ? S_UIR : S_PIR;
        S_PIR: tap_next = m ? S_E2IR : S_PIR;
        S_E2IR: tap_next = m ? S_UIR : S_SHIR;
        S_UIR: tap_next = m ? S_SDS : S_RTI;
        default: tap_next = S_TLR;
      endcase
    end
  endfunction

  // Length of the data register selected by an instruction
  function [5:0] dr_len;
    input [`JIE_IR_LEN-1:0] ins;
    begin
      case (ins)
        `JIE_INS_SAMPLE, `JIE_INS_EXTEST: dr_len = `JIE_BSR_LEN;
        `JIE_INS_IDCODE: dr_len = `JIE_IDCODE_LEN;
        `JIE_INS_ISC_PROGRAM: dr_len = `JIE_PROG_LEN;
        default: dr_len = 6'd1;
      endcase
    end
  endfunction

  // Shift right by one, inserting the new bit at the top of the chosen length
  function [`JIE_DR_MAX-1:0] dr_shift;
    input [`JIE_DR_MAX-1:0] v;
    input b;
    input [5:0] len;
    integer i;
    begin
      dr_shift = {`JIE_DR_MAX{1'b0}};
      for (i = 0; i < `JIE_DR_MAX; i = i + 1) begin
        if (i == len - 1)
          dr_shift[i] = b;
        else if (i < len - 1)
          dr_shift[i] = v[i+1];
      end
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // TAP state, instruction and data registers, on rising TCK

  reg [15:0] tap;
  reg [`JIE_IR_LEN-1:0] ir;
  reg [`JIE_IR_LEN-1:0] ir_sh;
  reg [`JIE_DR_MAX-1:0] dr;
  reg [`JIE_BSR_LEN-1:0] bsr_hold;
  reg programmed;
  reg strap_taken;
  wire [5:0] cur_len = dr_len(ir);

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tap <= S_TLR;
      ir <= `JIE_INS_IDCODE;
      ir_sh <= {`JIE_IR_LEN{1'b0}};
      dr <= {`JIE_DR_MAX{1'b0}};
      bsr_hold <= {`JIE_BSR_LEN{1'b0}};
      isc_mode <= 1'b0;
      isc_refused <= 1'b0;
      programmed <= 1'b0;
      strap_taken <= 1'b0;
      prog_we <= 1'b0;
      prog_data <= {`JIE_PROG_LEN{1'b0}};
    end else begin
      prog_we <= 1'b0;
      // Array contents are caught once, the cycle after reset release
      if (!strap_taken) begin
        strap_taken <= 1'b1;
        programmed <= array_valid;
      end
      if (trst_s) begin
        tap <= S_TLR;
        ir <= `JIE_INS_IDCODE;
      end else if (tck_rise) begin
        tap <= tap_next(tap, tms_s);
        case (tap)
          S_TLR: begin
            ir <= `JIE_INS_IDCODE;
          end
          S_CIR: begin
            ir_sh <= `JIE_IR_CAPTURE;
          end
          S_SHIR: begin
            ir_sh <= {tdi_s, ir_sh[`JIE_IR_LEN-1:1]};
          end
          S_UIR: begin
            ir <= ir_sh;
            // Programming entry is blocked while frozen
            if (ir_sh == `JIE_INS_ISC_ENABLE) begin
              if (freeze_mode) begin
                isc_refused <= 1'b1;
              end else begin
                isc_mode <= 1'b1;
                isc_refused <= 1'b0;
                programmed <= 1'b0;
              end
            end else if (ir_sh == `JIE_INS_ISC_DISABLE && isc_mode) begin
              isc_mode <= 1'b0;
              programmed <= prog_ok;
            end
          end
          S_CDR: begin
            case (ir)
              `JIE_INS_SAMPLE, `JIE_INS_EXTEST: begin
                // Parallel capture of every pad cell
                dr <= {8'h00, core_oe, core_out, pad_s};
              end
              `JIE_INS_IDCODE: dr <= IDCODE_VALUE;
              default: dr <= {`JIE_DR_MAX{1'b0}};
            endcase
          end
          S_SHDR: begin
            dr <= dr_shift(dr, tdi_s, cur_len);
          end
          S_UDR: begin
            if (ir == `JIE_INS_SAMPLE)
              bsr_hold <= dr[`JIE_BSR_LEN-1:0];
            // Program words only reach the array inside programming mode
            if (ir == `JIE_INS_ISC_PROGRAM && isc_mode) begin
              prog_we <= 1'b1;
              prog_data <= dr[`JIE_PROG_LEN-1:0];
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // TDO launch on falling TCK, and the global I/O enable

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      tdo <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (trst_s) begin
      tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      tdo <= (tap == S_SHIR) ? ir_sh[0] : dr[0];
      tdo_oe <= (tap == S_SHIR) || (tap == S_SHDR);
    end
  end

  // I/O stays off until a valid array is in place and programming is over
  always @(posedge clk or posedge rst) begin
    if (rst)
      io_en <= `JIE_IO_EN_RESET;
    else
      io_en <= programmed & ~isc_mode & strap_taken;
  end

endmodule // jie_tap

// File: tb/jie_tap_props.sv
// Checker for the programming-entry and I/O control block
`timescale 1ns/1ps
module jie_tap_props (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Device state
  input wire freeze_mode,
  input wire prog_ok,
  // Outputs watched
  input wire tdo,
  input wire io_en,
  input wire isc_mode,
  input wire isc_refused,
  input wire prog_we
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_refuse_frozen: assert property ($rose(isc_refused) |-> freeze_mode && !isc_mode)
    else $error("refusal seen without freeze");
  a_enter_thawed: assert property ($rose(isc_mode) |-> !freeze_mode && !isc_refused)
    else $error("programming entered while frozen");
  a_io_off_prog: assert property (isc_mode |=> !io_en)
    else $error("io enable high during programming");
  a_io_rise_idle: assert property ($rose(io_en) |-> !isc_mode && !$past(isc_mode))
    else $error("io enable rose while programming");
  a_io_after_exit: assert property ($fell(isc_mode) |=> io_en == $past(prog_ok))
    else $error("io enable does not follow result");
  a_we_one_cycle: assert property (prog_we |=> !prog_we)
    else $error("program strobe longer than one cycle");
  a_we_in_mode: assert property (prog_we |-> isc_mode)
    else $error("program strobe outside programming");
  // A TCK period spans at least five clocks, so the shifted bit stands that long
  a_tdo_stands: assert property ($changed(tdo) |=> $stable(tdo) [*4])
    else $error("tdo changed too soon");
  c_refused: cover property ($rose(isc_refused));
  c_word: cover property (prog_we);
  c_io_on: cover property ($rose(io_en));
endmodule // jie_tap_props
bind jie_tap jie_tap_props jie_tap_props_inst (.clk(clk), .rst(rst), .freeze_mode(freeze_mode),
  .prog_ok(prog_ok), .tdo(tdo), .io_en(io_en), .isc_mode(isc_mode), .isc_refused(isc_refused), .prog_we(prog_we));

// File: tb/jie_prog_model.sv
// Behavioural JTAG programmer driving the test access port
`timescale 1ns/1ps
module jie_prog_model (
  // Pacing clock
  input wire clk,
  // Test access port
  output reg tck,
  output reg tms,
  output reg tdi,
  output reg trst_n,
  input wire tdo
);
  // TCK parked low between frames, data lines at pull-up level, TAP reset pulsed
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    trst_n = 1'b0;
    repeat (10) @(negedge clk);
    trst_n = 1'b1;
  end
  // One 800 ns TCK period; pins change while TCK is low, tdo taken at the rise
  task tick(input m, input d, output o);
    begin
      tms = m;
      tdi = d;
      repeat (4) @(negedge clk);
      tck = 1'b1;
      o = tdo;
      repeat (4) @(negedge clk);
      tck = 1'b0;
    end
  endtask
  // Idle to shift, n bits LSB first, update, back to idle
  task scan(input ir, input [31:0] v, input [5:0] n, output [31:0] r);
    integer i;
    reg o;
    begin
      r = 32'h0;
      tick(1'b1, 1'b1, o);
      if (ir) tick(1'b1, 1'b1, o);
      tick(1'b0, 1'b1, o);
      tick(1'b0, 1'b1, o);
      for (i = 0; i < n; i = i + 1) begin
        tick(i == n - 1, v[i], o);
        r[i] = o;
      end
      tick(1'b1, 1'b1, o);
      tick(1'b0, 1'b1, o);
    end
  endtask
endmodule // jie_prog_model

// File: tb/testbench.sv
// Self-checking bench for the programming-entry and I/O control block
`timescale 1ns/1ps
`include "jie_consts.vh"
module testbench;
  reg clk, rst, freeze_mode, array_valid, prog_ok;
  reg [`JIE_PADS-1:0] pad_in, core_out, core_oe, got;
  wire tck, tms, tdi, trst_n, tdo, tdo_oe, io_en, isc_mode, isc_refused, prog_we;
  wire [`JIE_PROG_LEN-1:0] prog_data;
  // Arbitrary identification value handed to the device under test
  localparam [31:0] ID_EXP = 32'h0000_1001;
  // A released TDO shows the inverse of its last level, so a missing enable corrupts the bits read
  wire tdo_pin = tdo_oe ? tdo : ~tdo;
  reg [31:0] r, w;
  integer err_total, checked, cyc, k;
  jie_prog_model prg (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo_pin));
  jie_tap #(.IDCODE_VALUE(ID_EXP)) jie_tap_inst (.clk(clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi),
    .trst_n(trst_n), .tdo(tdo),
    .tdo_oe(tdo_oe), .pad_in(pad_in), .core_out(core_out), .core_oe(core_oe), .freeze_mode(freeze_mode),
    .array_valid(array_valid), .prog_ok(prog_ok), .io_en(io_en), .isc_mode(isc_mode), .isc_refused(isc_refused),
    .prog_we(prog_we), .prog_data(prog_data));
  ////////////////////////////////////////////////////////////////////////
  // Expected boundary chain: enables high, outputs middle, pads low
  function [23:0] bsr_exp(input [7:0] oe, input [7:0] out, input [7:0] pad);
    bsr_exp = {oe, out, pad};
  endfunction
  task check(input string name, input [31:0] seen, input [31:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task close_out;
    begin
      $display("checked %0d err_total %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  // Clock and hang guard; the run needs well under 8000 cycles
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total = err_total + 1;
      close_out;
    end
  end
  // Keep the last word strobed out
  always @(posedge clk) if (prog_we === 1'b1) got <= prog_data;
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {rst, freeze_mode, array_valid, prog_ok} = 4'h8;
    {pad_in, core_out, core_oe, got} = 32'h0;
    {err_total, checked, cyc} = 0;
    k = $urandom(32'h2add2f8b);
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (12) @(negedge clk);
    check("io_en blank", io_en, 0);
    // TAP sits in test-logic-reset after TRST; one low TMS tick brings it to idle
    prg.tick(1'b0, 1'b1, r[0]);
    prg.scan(1'b0, 32'h0, `JIE_IDCODE_LEN, r);
    check("idcode", r, ID_EXP);
    for (k = 0; k < 3; k = k + 1) begin
      pad_in = (k == 0) ? 8'hff : $urandom;
      core_out = $urandom;
      core_oe = $urandom;
      prg.scan(1'b1, (k == 2) ? `JIE_INS_EXTEST : `JIE_INS_SAMPLE, 6'h4, r);
      check("ir capture", r[3:0], `JIE_IR_CAPTURE);
      check("tdo_oe idle", tdo_oe, 0);
      prg.scan(1'b0, $urandom, `JIE_BSR_LEN, r);
      check("bsr", r[23:0], bsr_exp(core_oe, core_out, pad_in));
      check("bsr inputs", r[7:0], pad_in);
    end
    freeze_mode = 1'b1;
    prg.scan(1'b1, `JIE_INS_ISC_ENABLE, 6'h4, r);
    repeat (3) @(negedge clk);
    check("refused", isc_refused, 1);
    check("mode frozen", isc_mode, 0);
    freeze_mode = 1'b0;
    for (k = 0; k < 2; k = k + 1) begin
      prog_ok = k;
      w = $urandom;
      prg.scan(1'b1, `JIE_INS_ISC_ENABLE, 6'h4, r);
      repeat (3) @(negedge clk);
      check("mode", {isc_mode, isc_refused, io_en}, 3'h4);
      prg.scan(1'b1, `JIE_INS_ISC_PROGRAM, 6'h4, r);
      prg.scan(1'b0, w, `JIE_PROG_LEN, r);
      repeat (3) @(negedge clk);
      check("word", got, w[7:0]);
      prg.scan(1'b1, `JIE_INS_ISC_DISABLE, 6'h4, r);
      repeat (3) @(negedge clk);
      check("io_en done", {isc_mode, io_en}, k);
      prg.scan(1'b1, `JIE_INS_ISC_PROGRAM, 6'h4, r);
      prg.scan(1'b0, ~w, `JIE_PROG_LEN, r);
      repeat (3) @(negedge clk);
      check("word outside", got, w[7:0]);
    end
    array_valid = 1'b1;
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    check("io_en valid", io_en, 1);
    close_out;
  end
endmodule // testbench
